// [design/ccms_top.v]
// cpu clock mode select: strap capture, prescaler and digital pll model
// assumes osc_in is a slow external clock, well under clk_sys/4;
// the cpu clock is produced as an enable-style level on clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "ccms_defines.vh"
// Notes on behaviour
// - mode equals port0 upper byte bits 7..5
// - decode eight codes to factor or path
// - prescaler mode halves the oscillator frequency
// - prescaler phases each last one oscillator period
// - multiplier modes enable pll, f times factor
// - resync pll every n-th oscillator transition
// - resync adjusts gradually, stays locked
module ccms_top (
   // clock, reset, enable
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        clk_en,
   // pins
   input  wire [7:0]  port0_upper_byte,
   input  wire        osc_in,
   // outputs
   output reg         cpu_clk_ff,
   output reg  [2:0]  clock_mode_select_ff,
   output reg         pll_enable_ff,
   output reg         prescaler_active_ff,
   output reg         resync_pulse_ff
);
   localparam ST_CAPT = 2'b01;
   localparam ST_RUN  = 2'b10;

   reg        rst_s1_ff, rst_s2_ff;
   reg [2:0]  mode_s1_ff, mode_s2_ff;
   reg        osc_s1_ff, osc_s2_ff, osc_d_ff;
   reg [1:0]  state_ff;
   reg [1:0]  nxt_state;
   reg [15:0] per_cnt_ff;
   reg [15:0] per_meas_ff;
   reg [15:0] step_ff;
   reg [15:0] acc_ff;
   reg [2:0]  trans_cnt_ff;
   reg        nxt_cpu_clk;
   wire       rst_int_n = rst_s2_ff;
   wire       osc_edge  = osc_s2_ff ^ osc_d_ff;
   wire       osc_rise  = osc_s2_ff & ~osc_d_ff;
   wire [3:0] factor_x2;
   wire       use_pll, use_presc;
   wire [2:0] resync_n;
   wire       resync_now;
   wire [15:0] target;
   wire [16:0] acc_sum;

   // reset release through two flops
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end

   // mode strap synchroniser
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_s1_ff <= `CCMS_MODE_RESET;
         mode_s2_ff <= `CCMS_MODE_RESET;
      end else if (clk_en) begin
         mode_s1_ff <= port0_upper_byte[`CCMS_MODE_MSB:`CCMS_MODE_LSB];
         mode_s2_ff <= mode_s1_ff;
      end
   end

   // oscillator synchroniser plus one flop of history for edges
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         osc_s1_ff <= 1'b0;
         osc_s2_ff <= 1'b0;
         osc_d_ff  <= 1'b0;
      end else if (clk_en) begin
         osc_s1_ff <= osc_in;
         osc_s2_ff <= osc_s1_ff;
         osc_d_ff  <= osc_s2_ff;
      end
   end

   always @* begin
      case (state_ff)
         ST_CAPT: nxt_state = ST_RUN;
         ST_RUN:  nxt_state = ST_RUN;
         default: nxt_state = ST_CAPT;
      endcase
   end

   // strap caught once after release, held until next reset
   always @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         state_ff             <= ST_CAPT;
         clock_mode_select_ff <= `CCMS_MODE_RESET;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         if (state_ff == ST_CAPT)
            clock_mode_select_ff <= mode_s2_ff;
      end
   end

   ccms_mode_dec u_dec (
      .mode      (clock_mode_select_ff),
      .factor_x2 (factor_x2),
      .use_pll   (use_pll),
      .use_presc (use_presc),
      .resync_n  (resync_n)
   );

   wire [19:0] quot;
   wire [15:0] half_acc;
   reg  [15:0] nxt_step;
   reg  [15:0] nxt_acc;

   // run state decode, shared by every output path but clock_mode_select_ff
   function is_run;
      input [1:0] st;
      begin
         is_run = (st == ST_RUN);
      end
   endfunction

   assign resync_now = osc_edge && (trans_cnt_ff == resync_n - 3'h1);
   // step per clk_sys so acc wraps factor times per osc period
   assign quot     = ({4'h0, factor_x2} * 20'h08000) / {4'h0, per_meas_ff};
   // a very short period would overflow the step: saturate instead
   assign target   = per_meas_ff == 16'h0000 ? 16'h0000
                     : (quot[19:16] != 4'h0 ? 16'hFFFF : quot[15:0]);
   assign acc_sum  = {1'b0, acc_ff} + {1'b0, step_ff};
   // signed half of the phase offset, sign bit kept
   assign half_acc = {acc_sum[15], acc_sum[15:1]};

   always @* begin
      nxt_cpu_clk = cpu_clk_ff;
      if (use_presc) begin
         if (osc_rise)
            nxt_cpu_clk = ~cpu_clk_ff;
      end else if (!use_pll) begin
         nxt_cpu_clk = osc_s2_ff;
      end else begin
         nxt_cpu_clk = acc_sum[15];
      end
   end

   // output flags and cpu clock level
   always @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         cpu_clk_ff          <= 1'b0;
         pll_enable_ff       <= 1'b0;
         prescaler_active_ff <= 1'b0;
         resync_pulse_ff     <= 1'b0;
      end else if (clk_en) begin
         pll_enable_ff       <= use_pll && is_run(state_ff);
         prescaler_active_ff <= use_presc && is_run(state_ff);
         cpu_clk_ff          <= is_run(state_ff) ? nxt_cpu_clk : 1'b0;
         // no pulse in the capture cycle, before the enables rise
         resync_pulse_ff     <= resync_now && use_pll && is_run(state_ff);
      end
   end

   // osc period in clk_sys cycles; saturates on a stopped oscillator
   always @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         per_cnt_ff  <= 16'h0000;
         per_meas_ff <= 16'h0000;
      end else if (clk_en) begin
         if (osc_rise) begin
            per_cnt_ff  <= 16'h0001;
            per_meas_ff <= per_cnt_ff;
         end else if (per_cnt_ff != 16'hFFFF) begin
            per_cnt_ff <= per_cnt_ff + 16'h0001;
         end
      end
   end

   // osc transitions since the last resync
   always @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         trans_cnt_ff <= 3'h0;
      end else if (clk_en && osc_edge) begin
         trans_cnt_ff <= resync_now ? 3'h0 : trans_cnt_ff + 3'h1;
      end
   end

   // slew step by 1/8 of error plus one: no abrupt frequency jump
   always @* begin
      nxt_step = step_ff;
      if (resync_now && use_pll) begin
         if (target > step_ff)
            nxt_step = step_ff + ((target - step_ff) >> 3) + 16'h0001;
         else if (target < step_ff)
            nxt_step = step_ff - ((step_ff - target) >> 3) - 16'h0001;
      end
   end

   // phase nudge halves the signed offset; bit 15 keeps its level except from a sum of 16'hFFFF, which goes to zero
   always @* begin
      nxt_acc = acc_sum[15:0];
      if (resync_now && use_pll)
         nxt_acc = acc_sum[15:0] - half_acc;
   end

   // nco state
   always @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         step_ff <= 16'h0000;
         acc_ff  <= 16'h0000;
      end else if (clk_en) begin
         step_ff <= nxt_step;
         acc_ff  <= nxt_acc;
      end
   end
endmodule // ccms_top
`default_nettype wire

// [design/ccms_defines.vh]
// constants for the cpu clock mode select block
// assumes inclusion by bare name from design files
`ifndef CCMS_DEFINES_VH
`define CCMS_DEFINES_VH
// clock_mode_select pin position in port0_upper_byte
`define CCMS_MODE_MSB     7
`define CCMS_MODE_LSB     5
// mode codes
`define CCMS_MODE_X4      3'h7
`define CCMS_MODE_X3      3'h6
`define CCMS_MODE_X2      3'h5
`define CCMS_MODE_X5      3'h4
`define CCMS_MODE_DIRECT  3'h3
`define CCMS_MODE_X1P5    3'h2
`define CCMS_MODE_PRESC   3'h1
`define CCMS_MODE_X2P5    3'h0
`define CCMS_MODE_RESET   3'h7
// factor kept in halves: numerator of f_cpu = f_osc * num / 2
`define CCMS_NUM_W        4
// phase accumulator width
`define CCMS_ACC_W        16
`endif

// [design/ccms_mode_dec.v]
// mode decoder: clock_mode_select to factor and path flags
// assumes a registered mode input from the same clock
`timescale 1ns/10ps
`default_nettype none
`include "ccms_defines.vh"
module ccms_mode_dec (
   // mode in
   input  wire [2:0]               mode,
   // decoded
   output reg  [`CCMS_NUM_W-1:0]   factor_x2,
   output reg                      use_pll,
   output reg                      use_presc,
   output reg  [2:0]               resync_n
);
   always @* begin
      factor_x2 = 4'h8;
      use_pll   = 1'b1;
      use_presc = 1'b0;
      resync_n  = 3'h4;
      case (mode)
         `CCMS_MODE_X4:     begin factor_x2 = 4'h8; resync_n = 3'h4; end
         `CCMS_MODE_X3:     begin factor_x2 = 4'h6; resync_n = 3'h3; end
         `CCMS_MODE_X2:     begin factor_x2 = 4'h4; resync_n = 3'h2; end
         `CCMS_MODE_X5:     begin factor_x2 = 4'hA; resync_n = 3'h5; end
         `CCMS_MODE_DIRECT: begin factor_x2 = 4'h2; use_pll = 1'b0; resync_n = 3'h1; end
         // non-integer factors: resync on the whole-period boundary
         `CCMS_MODE_X1P5:   begin factor_x2 = 4'h3; resync_n = 3'h2; end
         `CCMS_MODE_PRESC:  begin factor_x2 = 4'h1; use_pll = 1'b0; use_presc = 1'b1; resync_n = 3'h1; end
         `CCMS_MODE_X2P5:   begin factor_x2 = 4'h5; resync_n = 3'h2; end
         default:           begin factor_x2 = 4'h8; resync_n = 3'h4; end
      endcase
   end
endmodule // ccms_mode_dec
`default_nettype wire

// [tb/ccms_properties.sv]
// checker for the cpu clock mode select ports
// assumes osc half period of at least 8 clk_sys cycles
`timescale 1ns/10ps
`default_nettype none
module ccms_props (
   // watched
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       osc_in,
   input wire logic       cpu_clk_ff,
   input wire logic [2:0] clock_mode_select_ff,
   input wire logic       pll_enable_ff,
   input wire logic       prescaler_active_ff,
   input wire logic       resync_pulse_ff
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_presc_fall;
      prescaler_active_ff && $fell(osc_in);
   endsequence
   chk_mode_held: assert property ((pll_enable_ff || prescaler_active_ff) |=> $stable(clock_mode_select_ff))
      else $error("mode moved");
   chk_presc_code: assert property (prescaler_active_ff |-> clock_mode_select_ff == 3'h1)
      else $error("presc code");
   chk_path_one: assert property (!(pll_enable_ff && prescaler_active_ff))
      else $error("two paths");
   chk_presc_rise: assert property (prescaler_active_ff && $rose(osc_in) |-> ##[2:6] $changed(cpu_clk_ff))
      else $error("no toggle");
   // a toggle on the falling edge would double the rate
   chk_presc_fall: assert property (s_presc_fall |=> $stable(cpu_clk_ff)[*5])
      else $error("fall toggle");
   chk_direct_follow: assert property (clock_mode_select_ff == 3'h3 && $changed(osc_in)
      |-> ##[2:6] cpu_clk_ff == osc_in)
      else $error("direct lag");
   chk_resync_pll: assert property (resync_pulse_ff |-> pll_enable_ff ##1 !resync_pulse_ff)
      else $error("bad resync");
   // lock takes tens of resyncs from a zero step; judge only once settled
   logic [6:0] rs_seen;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) rs_seen <= 7'h00;
      else if (resync_pulse_ff && rs_seen != 7'h7F) rs_seen <= rs_seen + 7'h01;
   end
   chk_pll_runs: assert property (pll_enable_ff && rs_seen >= 7'h5A |-> ##[1:60] $changed(cpu_clk_ff))
      else $error("pll stalled");
endmodule // ccms_props
bind ccms_top ccms_props ccms_props_i (.clk_sys, .rst_n, .osc_in, .cpu_clk_ff, .clock_mode_select_ff,
   .pll_enable_ff, .prescaler_active_ff, .resync_pulse_ff);
`default_nettype wire

// [tb/ccms_osc_model.sv]
// free-running oscillator model
// assumes clk_sys as its timing base
`timescale 1ns/10ps
`default_nettype none
module ccms_osc_model (
   // timing
   input wire logic       clk_sys,
   input wire logic [7:0] half,
   // pin
   output var logic       osc
);
   logic [7:0] cnt = 8'h00;
   initial osc = 1'b0;
   always @(posedge clk_sys) begin
      cnt <= (cnt + 8'h01 >= half) ? 8'h00 : cnt + 8'h01;
      if (cnt + 8'h01 >= half) osc <= ~osc;
   end
endmodule // ccms_osc_model
`default_nettype wire

// [tb/tb_ccms_top.sv]
// self-checking bench for the cpu clock mode select
// assumes the oscillator model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb_ccms_top;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] strap = 8'hE0;
   logic       osc, cpu_clk, pll_en, presc, resync;
   logic [2:0] mode;
   int         errors = 0;
   int         checks_done = 0;
   always #12.5 clk_sys = ~clk_sys;
   ccms_osc_model ccms_osc_model_i (.clk_sys(clk_sys), .half(8'h18), .osc(osc));
   ccms_top ccms_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .port0_upper_byte(strap),
      .osc_in(osc), .cpu_clk_ff(cpu_clk), .clock_mode_select_ff(mode), .pll_enable_ff(pll_en),
      .prescaler_active_ff(presc), .resync_pulse_ff(resync));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         errors++;
         $display("ERROR %0t seen %0h want %0h", $time, seen, want);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // osc period 48 cycles, window of 30 periods; tog and rs per window
   task automatic measure(input logic [2:0] code, input int tog, input int rs);
      int nt;
      int nr;
      logic last;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      strap <= {code, 5'h15};
      repeat (4) @(posedge clk_sys);
      #1 check(mode, 3'h7);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check(mode, code);
      strap <= ~strap;
      // the pll starts from a zero step and needs many resyncs to lock
      repeat (9000) @(posedge clk_sys);
      check(mode, code);
      check({pll_en, presc}, code == 3'h1 ? 2'h1 : code == 3'h3 ? 2'h0 : 2'h2);
      nt = 0;
      nr = 0;
      last = cpu_clk;
      repeat (1440) begin
         @(posedge clk_sys);
         #1;
         nt += (cpu_clk !== last);
         last = cpu_clk;
         nr += resync;
      end
      // pll tolerance covers clk_sys quantisation
      check(nt >= tog - tog / 32 - 2 && nt <= tog + tog / 32 + 2, 1'b1);
      check(nr >= rs - 1 && nr <= rs + 1, 1'b1);
   endtask
   initial begin
      measure(3'h1, 30, 0);
      measure(3'h3, 60, 0);
      measure(3'h7, 240, 15);
      measure(3'h6, 180, 20);
      measure(3'h5, 120, 30);
      measure(3'h4, 300, 12);
      measure(3'h2, 90, 30);
      measure(3'h0, 150, 30);
      results;
   end
endmodule // tb_ccms_top
`default_nettype wire
